/* tb/otg_peer.sv */
/* Remote OTG peer: role and line events as pin levels.
   Assumes the bench picks an action code on clk. */
`timescale 1ns/100ps
module otg_peer (
  input  wire logic [4:0] act,
  output wire logic       id_a_role, remote_connect, remote_disconnect,
  output wire logic       srp_data_pulse, srp_vbus_pulse, host_suspended
);
  assign {srp_vbus_pulse, srp_data_pulse, remote_disconnect,
    remote_connect, id_a_role} = act;
  // A peer doing SRP means the host side sits in suspend
  assign host_suspended = act[3] | act[4];
endmodule

/* tb/otg_port_checks_properties.sv */
/* Concurrent checks on the OTG control block ports.
   Assumes one clk domain and an APB master that holds each request. */
`timescale 1ns/100ps
module otg_port_checks (
  // Bus
  input wire        clk, rst_n, psel, penable, pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  input wire        pready, pslverr,
  // Port
  input wire        remote_connect, host_bus_reset, xcvr_owner_sel,
  input wire        dm_pulldown_on, charge_pump_on,
  input wire        host_power_switch_pin_n, vbus_charge_on,
  input wire        vbus_discharge_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ready_next_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  rsvd_zero_a: assert property (pready && !pwrite |-> prdata[31:12] == 0)
    else $error("upper read bits set");
  ctrl_apply_a: assert property (pready && !pslverr && pwrite &&
    paddr == 12'h188 |-> ##2 xcvr_owner_sel == $past(pwdata[8], 2) &&
    dm_pulldown_on == $past(pwdata[7], 2)) else $error("controls stale");
  src_excl_a: assert property (!(charge_pump_on && !host_power_switch_pin_n))
    else $error("two vbus sources");
  role_excl_a: assert property (vbus_charge_on || vbus_discharge_on |->
    !charge_pump_on && host_power_switch_pin_n) else $error("vbus clash");
  se0_pulse_a: assert property (host_bus_reset |=> !host_bus_reset)
    else $error("bus reset held");
  se0_cause_a: assert property (host_bus_reset |-> $past(remote_connect, 2))
    else $error("bus reset unprompted");
  cover property (host_bus_reset);
  cover property (pready && pslverr);
  cover property (charge_pump_on);
endmodule
bind otg_port_control_register otg_port_checks u_chk (.clk, .rst_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .remote_connect, .host_bus_reset, .xcvr_owner_sel, .dm_pulldown_on,
  .charge_pump_on, .host_power_switch_pin_n, .vbus_charge_on,
  .vbus_discharge_on);

/* tb/test_otg_port_control_register.sv */
/* Table-driven bench for the OTG control block.
   Assumes APB answers with pready; peer acts via otg_peer. */
`timescale 1ns/100ps
module test_otg_port_control_register;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [4:0]  act = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr, id_a_role, remote_connect, remote_disconnect;
  wire         srp_vbus_pulse, srp_data_pulse, host_suspended, host_bus_reset;
  wire         host_wake, xcvr_owner_sel, dm_pulldown_on, dp_pulldown_on;
  wire         dp_pullup_on, charge_pump_on, host_power_switch_pin_n;
  wire         vbus_discharge_on, vbus_charge_on;
  wire  [8:0]  outs = {host_wake, xcvr_owner_sel, dm_pulldown_on,
    dp_pulldown_on, dp_pullup_on, charge_pump_on, host_power_switch_pin_n,
    vbus_discharge_on, vbus_charge_on};
  int errors = 0, checks_done = 0, pulses = 0, pexp = 0, i, n;
  // Row: value, peer action, expected controls, bus reset pulse
  logic [30:0] rows [11] = '{{16'hf1d0,5'h01,9'h0f4,1'b0},
    {16'h0000,5'h01,9'h004,1'b0}, {16'h0001,5'h01,9'h00c,1'b0},
    {16'h0009,5'h01,9'h000,1'b0}, {16'h0006,5'h00,9'h007,1'b0},
    {16'h0020,5'h05,9'h014,1'b0}, {16'h0600,5'h09,9'h104,1'b0},
    {16'h0400,5'h11,9'h104,1'b0}, {16'h0600,5'h11,9'h004,1'b0},
    {16'h0800,5'h02,9'h004,1'b1}, {16'h0000,5'h02,9'h004,1'b0}};
  otg_port_control_register dut (.clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .id_a_role,
    .remote_connect, .remote_disconnect, .srp_vbus_pulse, .srp_data_pulse,
    .host_suspended, .host_bus_reset, .host_wake, .xcvr_owner_sel,
    .dm_pulldown_on, .dp_pulldown_on, .dp_pullup_on, .charge_pump_on,
    .host_power_switch_pin_n, .vbus_discharge_on, .vbus_charge_on);
  otg_peer peer (.act, .id_a_role, .remote_connect, .remote_disconnect,
    .srp_data_pulse, .srp_vbus_pulse, .host_suspended);
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) if (host_bus_reset === 1'b1) pulses++;
  task report_and_stop;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Extra lead edge keeps release and next setup in separate steps
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk) penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 20) begin
      errors++;
      report_and_stop;
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h188, 0);
    chk(err, 1'b1);
    for (i = 0; i < 11; i++) begin
      act <= rows[i][14:10] & 5'h01;
      repeat (6) @(posedge clk);
      apb(1'b1, 12'h000, 32'he2);
      apb(1'b1, 12'h188, rows[i][30:15]);
      act <= rows[i][14:10];
      pexp += rows[i][0];
      repeat (10) @(posedge clk);
      chk(outs, rows[i][9:1]);
      apb(1'b1, 12'h000, 32'h62);
      apb(1'b0, 12'h188, 0);
      chk(rd, rows[i][26:15]);
      chk(pulses, pexp);
      $display("row %0d done", i);
    end
    apb(1'b1, 12'h188, 32'hffff);
    chk(err, 1'b1);
    apb(1'b0, 12'h188, 0);
    chk(rd, 0);
    apb(1'b0, 12'h100, 0);
    chk(err, 1'b1);
    $display("refusal test done");
    report_and_stop;
  end
endmodule

/* verilog/otg_port_control_register.v */
/*
  OTG port control register with its port steering logic.
  Assumes an APB master on clk; role and line events arrive from pins
  and are synchronised here before use.
*/
// Register access over APB was decided locally.
`timescale 1ns/100ps
`include "otg_port_ctrl_map.vh"

module otg_port_control_register (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Port events and role, from pins
  input  wire        id_a_role,
  input  wire        remote_connect,
  input  wire        remote_disconnect,
  input  wire        srp_vbus_pulse,
  input  wire        srp_data_pulse,
  input  wire        host_suspended,
  // Port controls
  output reg         host_bus_reset,
  output reg         host_wake,
  output reg         xcvr_owner_sel,
  output reg         dm_pulldown_on,
  output reg         dp_pulldown_on,
  output reg         dp_pullup_on,
  output reg         charge_pump_on,
  output reg         host_power_switch_pin_n,
  output reg         vbus_discharge_on,
  output reg         vbus_charge_on
);


  // Register state
  reg  [15:0] ctrl;
  reg  [7:0]  cmd;
  reg         auto_pullup;
  reg  [1:0]  conn_d;

  // Pin levels before and after the two-flop crossing
  wire [5:0]  pin_raw;
  wire [5:0]  sync_q;

  // Synchronised pin levels
  wire        a_role;
  wire        rconn;
  wire        rdisc;
  wire        srp_vb;
  wire        srp_dl;
  wire        hc_susp;

  // Bus decode
  wire        access;
  wire        first;
  wire        second;
  wire        hit_ctrl;
  wire        hit_cmd;
  wire        hit_stat;
  wire        known;
  wire        cmd_wr;
  wire        cmd_rd;
  wire        bad;
  wire        rd_ok;
  wire        wr_ok;

  // Port control terms
  wire        srp_event;
  wire        rconn_rise;
  wire        rdisc_rise;
  wire        next_pullup;
  wire        drive;

  genvar      g;

  // True when the bus address selects the given byte address
  function sel;
    input [11:0] addr;
    input [11:0] target;
    begin
      sel = (addr == target);
    end
  endfunction

  assign pin_raw = {host_suspended, srp_data_pulse, srp_vbus_pulse,
                    remote_disconnect, remote_connect, id_a_role};

  // Pins cross into clk through two flops each
  generate
    for (g = 0; g < 6; g = g + 1) begin : pin_sync
      reg stage1;
      reg stage2;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else begin
          stage1 <= pin_raw[g];
          stage2 <= stage1;
        end
      end
      assign sync_q[g] = stage2;
    end
  endgenerate

  assign a_role  = sync_q[0];
  assign rconn   = sync_q[1];
  assign rdisc   = sync_q[2];
  assign srp_vb  = sync_q[3];
  assign srp_dl  = sync_q[4];
  assign hc_susp = sync_q[5];

  // Access phase: first cycle raises pready, second is the taken edge
  assign access   = psel & penable;
  assign first    = access & ~pready;
  assign second   = access & pready;

  assign hit_ctrl = sel(paddr, `OTG_CTRL_ADDR);
  assign hit_cmd  = sel(paddr, `OTG_CMD_ADDR);
  assign hit_stat = sel(paddr, `OTG_STAT_ADDR);
  assign known    = hit_ctrl | hit_cmd | hit_stat;

  // A control register access only counts once the matching code is loaded
  assign cmd_wr   = (cmd == `OTG_CTRL_WR_CODE);
  assign cmd_rd   = (cmd == `OTG_CTRL_RD_CODE);
  assign bad      = ~known |
                    (hit_ctrl & pwrite & ~cmd_wr) |
                    (hit_ctrl & ~pwrite & ~cmd_rd);

  // Read data is staged early so it stands when pready is seen
  assign rd_ok    = first & ~bad & ~pwrite;
  // Writes land only where the master sees pready high
  assign wr_ok    = second & ~bad & pwrite;

  assign srp_event  = ctrl[`BIT_SRP_METHOD] ? srp_dl : srp_vb;
  assign rconn_rise = rconn & ~conn_d[0];
  assign rdisc_rise = rdisc & ~conn_d[1];

  assign next_pullup = ctrl[`BIT_DP_PULLUP] | auto_pullup;
  assign drive       = ctrl[`BIT_VBUS_DRIVE] & a_role;

  // Edge detect on the synchronised connect lines
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conn_d <= 2'h0;
    end else begin
      conn_d <= {rdisc, rconn};
    end
  end

  // One-cycle ready pulse per access
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= first;
    end
  end

  // Error flag rides with the ready pulse
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= first & bad;
    end
  end

  // Read data, zero outside the ready cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (rd_ok & hit_ctrl) begin
      prdata <= {16'h0000, ctrl & `OTG_CTRL_WMASK};
    end else if (rd_ok & hit_cmd) begin
      prdata <= {24'h000000, cmd};
    end else if (rd_ok & hit_stat) begin
      prdata <= {26'h0000000, sync_q};
    end else begin
      prdata <= 32'h00000000;
    end
  end

  // Command code register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= 8'h00;
    end else if (wr_ok & hit_cmd) begin
      cmd <= pwdata[7:0];
    end
  end

  // Control register; reserved bits never store
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `OTG_CTRL_RESET;
    end else if (wr_ok & hit_ctrl) begin
      ctrl <= pwdata[15:0] & `OTG_CTRL_WMASK;
    end
  end

  // Auto pull-up holds until software drops the enable or the A role drops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_pullup <= 1'b0;
    end else if (!ctrl[`BIT_AUTO_CONN] || !a_role) begin
      auto_pullup <= 1'b0;
    end else if (rdisc_rise) begin
      auto_pullup <= 1'b1;
    end
  end

  // Bus reset is a single pulse per connect edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_bus_reset <= 1'b0;
    end else begin
      host_bus_reset <= ctrl[`BIT_SE0_CONN] & rconn_rise;
    end
  end

  // Wake request
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_wake <= 1'b0;
    end else begin
      host_wake <= ctrl[`BIT_SRP_WAKE] & a_role & hc_susp &
                   srp_event;
    end
  end

  // Transceiver owner
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xcvr_owner_sel <= 1'b1;
    end else begin
      xcvr_owner_sel <= ctrl[`BIT_XCVR_OWNER];
    end
  end

  // DM pull-down
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dm_pulldown_on <= 1'b1;
    end else begin
      dm_pulldown_on <= ctrl[`BIT_DM_PULLDN];
    end
  end

  // DP pull-down
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_pulldown_on <= 1'b1;
    end else begin
      dp_pulldown_on <= ctrl[`BIT_DP_PULLDN];
    end
  end

  // DP pull-up from the local bit or the auto latch
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_pullup_on <= 1'b0;
    end else begin
      dp_pullup_on <= next_pullup;
    end
  end

  // On-chip charge pump
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_pump_on <= 1'b0;
    end else begin
      charge_pump_on <= drive & ~ctrl[`BIT_VBUS_SOURCE];
    end
  end

  // External supply switch, active low
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_power_switch_pin_n <= 1'b1;
    end else begin
      host_power_switch_pin_n <=
        ~(drive & ctrl[`BIT_VBUS_SOURCE]);
    end
  end

  // Discharge is gated by role so a stray A-side write stays harmless
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vbus_discharge_on <= 1'b0;
    end else begin
      vbus_discharge_on <= ctrl[`BIT_VBUS_DISCH] & ~a_role;
    end
  end

  // B-side charge through a resistor
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vbus_charge_on <= 1'b0;
    end else begin
      vbus_charge_on <= ctrl[`BIT_VBUS_CHARGE] & ~a_role;
    end
  end

  // The status word and the outputs both take the synchronised levels:
  // every control takes one clock after its register bit or synchronised pin
  // level settles, so most pins see three cycles of latency; the auto pull-up path to dp_pullup_on takes four.

endmodule

/* verilog/otg_port_ctrl_map.vh */
/*
  Register map and constants for the OTG port control register block.
  Assumes an APB master with 32-bit data; one register word per address.

  // How it works
  // - Remote connect sends bus reset when enabled
  // - SRP event wakes host from suspend
  // - SRP method: VBUS pulsing or data pulsing
  // - Transceiver routed to host or device engine
  // - DM pull-down follows its control bit
  // - DP pull-down follows its control bit
  // - Remote disconnect turns DP pull-up on
  // - DP pull-up follows local connect bit
  // - VBUS source: charge pump or external
  // - External source drives power switch pin
  // - B-device VBUS discharge pull-down
  // - B-device VBUS charge through resistor
  // - VBUS drive from selected source
  // - Read code 62h, write code e2h
*/
`ifndef OTG_PORT_CTRL_MAP_VH
`define OTG_PORT_CTRL_MAP_VH

`define OTG_CTRL_RD_CODE   8'h62
`define OTG_CTRL_WR_CODE   8'he2
`define OTG_CTRL_ADDR      12'h188
`define OTG_CMD_ADDR       12'h000
`define OTG_STAT_ADDR      12'h004
`define OTG_CTRL_RESET     16'h01c0
`define OTG_CTRL_WMASK     16'h0fff

`define BIT_VBUS_DRIVE     0
`define BIT_VBUS_CHARGE    1
`define BIT_VBUS_DISCH     2
`define BIT_VBUS_SOURCE    3
`define BIT_DP_PULLUP      4
`define BIT_AUTO_CONN      5
`define BIT_DP_PULLDN      6
`define BIT_DM_PULLDN      7
`define BIT_XCVR_OWNER     8
`define BIT_SRP_METHOD     9
`define BIT_SRP_WAKE       10
`define BIT_SE0_CONN       11

`endif
